// File: logic/cmd_exec.sv
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cmd_exec (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // table memory port
  output logic tabReq,
  output logic tabWrite,
  output logic [1:0] tabSel,
  output logic [31:0] tabDev,
  output logic [31:0] tabIdx,
  output logic [63:0] tabWdata,
  input wire logic tabAck,
  input wire logic [63:0] tabRdata,
  // redistributor port
  output logic rdReq,
  output logic [1:0] rdOp,
  output logic [34:0] rdSrc,
  output logic [34:0] rdDst,
  output logic [31:0] rdId,
  input wire logic rdAck,
  // events
  output logic sysError,
  output logic irq
);
  // registers
  logic [3:0] ctrl_q;
  logic [31:0] limits_q;
  logic [4:0] idBits_q;
  logic [1:0] wrPtr_q;
  logic [1:0] rdPtr_q;
  logic [2:0] irqStat_q;
  logic [2:0] irqMask_q;
  logic [31:0] queue_q [cmd_exec_pkg::QUEUE_PACKETS*cmd_exec_pkg::PACKET_WORDS];
  cmd_exec_pkg::exec_state_t state_q, state_d;
  logic [7:0] opcode_q;
  logic [31:0] dev_q, evt_q, bell_q;
  logic [15:0] collection_id_q, vpe_q;
  logic [34:0] syncTgt_q, rd1_q;
  logic [63:0] ite_q;
  logic errHit;
  logic [2:0] irqSet;
  logic apbWr, apbRd, addrOk;
  logic [4:0] qWord;
  logic [31:0] readMux;
  logic tabDone, rdDone;
  logic [4:0] base;

  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && penable && !pwrite;
  assign qWord = paddr[6:2];
  assign tabDone = tabReq && tabAck;
  assign rdDone = rdReq && rdAck;
  assign base = {rdPtr_q, 3'h0};

  // address decode and read mux; the queue takes a 128-byte window
  always_comb begin
    addrOk = 1'b1;
    readMux = 32'h00000000;
    if (paddr[11:7] == cmd_exec_pkg::REG_QUEUE[11:7]) begin
      readMux = queue_q[qWord];
    end else begin
      case (paddr)
        cmd_exec_pkg::REG_CTRL: readMux = {28'h0000000, ctrl_q};
        cmd_exec_pkg::REG_LIMITS: readMux = limits_q;
        cmd_exec_pkg::REG_IDBITS: readMux = {27'h0000000, idBits_q};
        cmd_exec_pkg::REG_WRPTR: readMux = {30'h00000000, wrPtr_q};
        cmd_exec_pkg::REG_RDPTR: readMux = {30'h00000000, rdPtr_q};
        cmd_exec_pkg::REG_STATE: readMux = {31'h00000000, state_q != cmd_exec_pkg::S_IDLE};
        cmd_exec_pkg::REG_IRQ_STAT: readMux = {29'h00000000, irqStat_q};
        cmd_exec_pkg::REG_IRQ_MASK: readMux = {29'h00000000, irqMask_q};
        default: addrOk = 1'b0;
      endcase
    end
  end

  // zero wait state slave; error answer on unmapped offsets
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      prdata <= (psel && !penable && !pwrite) ? readMux : 32'h00000000;
    end
  end

  // configuration registers written by software
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= cmd_exec_pkg::CTRL_RESET;
      limits_q <= cmd_exec_pkg::LIMITS_RESET;
      idBits_q <= cmd_exec_pkg::IDBITS_RESET;
      wrPtr_q <= 2'h0;
      irqMask_q <= 3'h0;
    end else if (apbWr && pready) begin
      case (paddr)
        cmd_exec_pkg::REG_CTRL: ctrl_q <= pwdata[3:0];
        cmd_exec_pkg::REG_LIMITS: limits_q <= pwdata;
        cmd_exec_pkg::REG_IDBITS: idBits_q <= pwdata[4:0];
        cmd_exec_pkg::REG_WRPTR: wrPtr_q <= pwdata[1:0];
        cmd_exec_pkg::REG_IRQ_MASK: irqMask_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // packet storage; software fills a slot before moving the write pointer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < cmd_exec_pkg::QUEUE_PACKETS*cmd_exec_pkg::PACKET_WORDS; i++) begin
        queue_q[i] <= 32'h00000000;
      end
    end else if (apbWr && pready && paddr[11:7] == cmd_exec_pkg::REG_QUEUE[11:7]) begin
      queue_q[qWord] <= pwdata;
    end
  end

  // check helpers
  function automatic logic lpiBad(input logic [31:0] id, input logic [4:0] bits);
    logic [32:0] top;
    top = 33'h000000001 << bits;
    lpiBad = (id < cmd_exec_pkg::LOCAL_INT_MIN) || ({1'b0, id} >= top);
  endfunction

  // sequencing and error checks, in documented order
  always_comb begin
    logic [5:0] sizeBits;
    sizeBits = {1'b0, tabRdata[cmd_exec_pkg::DEV_SIZE_LO +: 5]} + 6'h01;
    state_d = state_q;
    errHit = 1'b0;
    case (state_q)
      cmd_exec_pkg::S_IDLE: begin
        if (ctrl_q[cmd_exec_pkg::CTRL_ENABLE] && rdPtr_q != wrPtr_q) begin
          state_d = cmd_exec_pkg::S_DECODE;
        end
      end
      cmd_exec_pkg::S_DECODE: begin
        case (opcode_q)
          cmd_exec_pkg::OP_COLL_MOVE: begin
            if (dev_q[31:cmd_exec_pkg::DEV_NUM_BITS] != 16'h0000) errHit = 1'b1;
            else if (collection_id_q >= limits_q[15:0]) errHit = 1'b1;
            else state_d = cmd_exec_pkg::S_DEV;
          end
          cmd_exec_pkg::OP_BARRIER: state_d = cmd_exec_pkg::S_SYNC;
          cmd_exec_pkg::OP_VIRT_INVAL: begin
            if (!ctrl_q[cmd_exec_pkg::CTRL_VIRT]) errHit = 1'b1;
            else if (vpe_q >= limits_q[31:16]) errHit = 1'b1;
            else state_d = cmd_exec_pkg::S_VPE;
          end
          cmd_exec_pkg::OP_VIRT_MAP: begin
            if (!ctrl_q[cmd_exec_pkg::CTRL_VIRT]) errHit = 1'b1;
            else if (dev_q[31:cmd_exec_pkg::DEV_NUM_BITS] != 16'h0000) errHit = 1'b1;
            else if (vpe_q >= limits_q[31:16]) errHit = 1'b1;
            else state_d = cmd_exec_pkg::S_DEV;
          end
          default: errHit = 1'b1; // commands not handled here are refused
        endcase
      end
      cmd_exec_pkg::S_DEV: begin
        if (tabDone) begin
          if (!tabRdata[cmd_exec_pkg::ENT_VALID]) errHit = 1'b1;
          else if ((evt_q >> sizeBits) != 32'h00000000) errHit = 1'b1;
          else if (opcode_q == cmd_exec_pkg::OP_COLL_MOVE) state_d = cmd_exec_pkg::S_ITE;
          else if (lpiBad(evt_q, idBits_q)) errHit = 1'b1;
          else if (bell_q != cmd_exec_pkg::NO_DOORBELL && lpiBad(bell_q, idBits_q)) begin
            errHit = 1'b1;
          end else state_d = cmd_exec_pkg::S_WRITE;
        end
      end
      cmd_exec_pkg::S_ITE: begin
        if (tabDone) begin
          if (!tabRdata[cmd_exec_pkg::ENT_VALID]) errHit = 1'b1;
          else if (tabRdata[cmd_exec_pkg::ENT_VIRT]) errHit = 1'b1;
          else state_d = cmd_exec_pkg::S_COL1;
        end
      end
      cmd_exec_pkg::S_COL1: begin
        if (tabDone) begin
          if (!tabRdata[cmd_exec_pkg::ENT_VALID]) errHit = 1'b1;
          else state_d = cmd_exec_pkg::S_COL2;
        end
      end
      cmd_exec_pkg::S_COL2: begin
        if (tabDone) begin
          if (!tabRdata[cmd_exec_pkg::ENT_VALID]) errHit = 1'b1;
          else if (tabRdata[35:1] != rd1_q) state_d = cmd_exec_pkg::S_MOVE;
          else state_d = cmd_exec_pkg::S_WRITE;
        end
      end
      cmd_exec_pkg::S_MOVE: if (rdDone) state_d = cmd_exec_pkg::S_WRITE;
      cmd_exec_pkg::S_WRITE: if (tabDone) state_d = cmd_exec_pkg::S_ADV;
      cmd_exec_pkg::S_SYNC: if (rdDone) state_d = cmd_exec_pkg::S_ADV;
      cmd_exec_pkg::S_VPE: begin
        if (tabDone) begin
          if (!tabRdata[cmd_exec_pkg::ENT_VALID]) errHit = 1'b1;
          else state_d = cmd_exec_pkg::S_INVAL;
        end
      end
      cmd_exec_pkg::S_INVAL: if (rdDone) state_d = cmd_exec_pkg::S_ADV;
      cmd_exec_pkg::S_ADV: state_d = cmd_exec_pkg::S_IDLE;
      default: state_d = cmd_exec_pkg::S_IDLE;
    endcase
    if (errHit) state_d = cmd_exec_pkg::S_ADV;
  end

  // state, read pointer and packet fields
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= cmd_exec_pkg::S_IDLE;
      rdPtr_q <= 2'h0;
      opcode_q <= 8'h00;
      dev_q <= 32'h00000000;
      evt_q <= 32'h00000000;
      bell_q <= 32'h00000000;
      collection_id_q <= 16'h0000;
      vpe_q <= 16'h0000;
      syncTgt_q <= 35'h000000000;
    end else begin
      state_q <= state_d;
      if (state_q == cmd_exec_pkg::S_ADV) rdPtr_q <= rdPtr_q + 2'h1;
      if (state_q == cmd_exec_pkg::S_IDLE) begin
        opcode_q <= queue_q[base][7:0];
        dev_q <= queue_q[base + 5'h01];
        evt_q <= queue_q[base + 5'h02];
        vpe_q <= queue_q[base + 5'h03][15:0];
        collection_id_q <= queue_q[base + 5'h04][15:0];
        bell_q <= queue_q[base + 5'h05];
        // processor numbers sit in bits 31:16, addresses span bits 50:16
        if (ctrl_q[cmd_exec_pkg::CTRL_TGTFMT]) begin
          syncTgt_q <= {queue_q[base + 5'h05][18:0], queue_q[base + 5'h04][31:16]};
        end else begin
          syncTgt_q <= {19'h00000, queue_q[base + 5'h04][31:16]};
        end
      end
    end
  end

  // translation entry under construction and first target
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ite_q <= 64'h0000000000000000;
      rd1_q <= 35'h000000000;
    end else begin
      if (state_q == cmd_exec_pkg::S_ITE && tabDone) ite_q <= tabRdata;
      if (state_q == cmd_exec_pkg::S_COL1 && tabDone) rd1_q <= tabRdata[35:1];
      if (state_q == cmd_exec_pkg::S_DEV && state_d == cmd_exec_pkg::S_WRITE) begin
        ite_q <= 64'h0000000000000000;
        ite_q[cmd_exec_pkg::ENT_VALID] <= 1'b1;
        ite_q[cmd_exec_pkg::ENT_VIRT] <= 1'b1;
        ite_q[cmd_exec_pkg::ENT_TGT_LO +: 16] <= vpe_q;
        ite_q[cmd_exec_pkg::ENT_OUT_LO +: 16] <= evt_q[15:0];
        ite_q[cmd_exec_pkg::ENT_BELL_LO +: 16] <= bell_q[15:0];
      end
      if (state_q == cmd_exec_pkg::S_COL2 && tabDone && !errHit) begin
        ite_q[cmd_exec_pkg::ENT_TGT_LO +: 16] <= collection_id_q;
      end
    end
  end

  // table port: request held until acknowledged; only the write state writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tabReq <= 1'b0;
      tabWrite <= 1'b0;
      tabSel <= cmd_exec_pkg::TAB_DEVICE;
      tabDev <= 32'h00000000;
      tabIdx <= 32'h00000000;
      tabWdata <= 64'h0000000000000000;
    end else begin
      if (tabAck) begin
        tabReq <= 1'b0;
        tabWrite <= 1'b0;
      end
      if (state_d != state_q) begin
        case (state_d)
          cmd_exec_pkg::S_DEV: begin
            tabReq <= 1'b1;
            tabSel <= cmd_exec_pkg::TAB_DEVICE;
            tabIdx <= dev_q;
          end
          cmd_exec_pkg::S_ITE: begin
            tabReq <= 1'b1;
            tabSel <= cmd_exec_pkg::TAB_TRANSLATION;
            tabDev <= dev_q;
            tabIdx <= evt_q;
          end
          cmd_exec_pkg::S_COL1: begin
            tabReq <= 1'b1;
            tabSel <= cmd_exec_pkg::TAB_COLLECTION;
            tabIdx <= {16'h0000, tabRdata[cmd_exec_pkg::ENT_TGT_LO +: 16]};
          end
          cmd_exec_pkg::S_COL2: begin
            tabReq <= 1'b1;
            tabSel <= cmd_exec_pkg::TAB_COLLECTION;
            tabIdx <= {16'h0000, collection_id_q};
          end
          cmd_exec_pkg::S_VPE: begin
            tabReq <= 1'b1;
            tabSel <= cmd_exec_pkg::TAB_VPE;
            tabIdx <= {16'h0000, vpe_q};
          end
          cmd_exec_pkg::S_WRITE: begin
            tabReq <= 1'b1;
            tabWrite <= 1'b1;
            tabSel <= cmd_exec_pkg::TAB_TRANSLATION;
            tabDev <= dev_q;
            tabIdx <= evt_q;
          end
          default: ;
        endcase
      end
      // entry content settles one cycle after entry, before any ack can come
      if (state_q == cmd_exec_pkg::S_WRITE) tabWdata <= ite_q;
    end
  end

  // redistributor port; the far side answers only once its work is observed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdReq <= 1'b0;
      rdOp <= cmd_exec_pkg::RD_MOVE;
      rdSrc <= 35'h000000000;
      rdDst <= 35'h000000000;
      rdId <= 32'h00000000;
    end else begin
      if (rdAck) rdReq <= 1'b0;
      if (state_d != state_q) begin
        case (state_d)
          cmd_exec_pkg::S_MOVE: begin
            rdReq <= 1'b1;
            rdOp <= cmd_exec_pkg::RD_MOVE;
            rdSrc <= rd1_q;
            rdDst <= tabRdata[35:1];
            rdId <= {16'h0000, ite_q[cmd_exec_pkg::ENT_OUT_LO +: 16]};
          end
          cmd_exec_pkg::S_SYNC: begin
            rdReq <= 1'b1;
            rdOp <= cmd_exec_pkg::RD_BARRIER;
            rdDst <= syncTgt_q;
          end
          cmd_exec_pkg::S_INVAL: begin
            rdReq <= 1'b1;
            rdOp <= cmd_exec_pkg::RD_INVAL;
            rdDst <= tabRdata[35:1];
            rdId <= {16'h0000, vpe_q};
          end
          default: ;
        endcase
      end
    end
  end

  // sticky events; a set in the clearing cycle survives
  assign irqSet = {state_q == cmd_exec_pkg::S_SYNC && rdDone, errHit,
    state_q == cmd_exec_pkg::S_ADV};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_q <= 3'h0;
      irq <= 1'b0;
      sysError <= 1'b0;
    end else begin
      if (apbWr && pready && paddr == cmd_exec_pkg::REG_IRQ_STAT) begin
        irqStat_q <= (irqStat_q & ~pwdata[2:0]) | irqSet;
      end else begin
        irqStat_q <= irqStat_q | irqSet;
      end
      irq <= |(irqStat_q & irqMask_q);
      sysError <= errHit && ctrl_q[cmd_exec_pkg::CTRL_SYSERR];
    end
  end

  // checks
  sequence errSeen;
    errHit;
  endsequence
  sequence advanced;
    state_q == cmd_exec_pkg::S_ADV ##1 state_q == cmd_exec_pkg::S_IDLE;
  endsequence

  AST_ERR_ADVANCES: assert property (@(posedge clk) disable iff (!rst_b)
    errSeen |=> advanced) else $error("error did not advance the queue");
  AST_SYSERR_GATED: assert property (@(posedge clk) disable iff (!rst_b)
    sysError |-> $past(errHit) && $past(ctrl_q[cmd_exec_pkg::CTRL_SYSERR]))
    else $error("system error without cause");
  AST_PTR_ONLY_ON_ADV: assert property (@(posedge clk) disable iff (!rst_b)
    rdPtr_q != $past(rdPtr_q) |-> $past(state_q) == cmd_exec_pkg::S_ADV)
    else $error("read pointer moved mid command");
  AST_WRITE_ONLY_IN_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    tabReq && tabWrite |-> state_q == cmd_exec_pkg::S_WRITE)
    else $error("table written outside write phase");
  AST_MOVE_ON_DIFF: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == cmd_exec_pkg::S_COL2 && tabDone && tabRdata[0] && tabRdata[35:1] != rd1_q
    |=> rdReq && rdOp == cmd_exec_pkg::RD_MOVE) else $error("pending state not moved");
  AST_MOVE_ENTRY: assert property (@(posedge clk) disable iff (!rst_b)
    tabDone && tabWrite && opcode_q == cmd_exec_pkg::OP_COLL_MOVE
    |-> tabWdata[cmd_exec_pkg::ENT_TGT_LO +: 16] == collection_id_q) else $error("wrong collection");
  AST_MAP_ENTRY: assert property (@(posedge clk) disable iff (!rst_b)
    tabDone && tabWrite && opcode_q == cmd_exec_pkg::OP_VIRT_MAP
    |-> tabWdata[1:0] == 2'h3 && tabWdata[cmd_exec_pkg::ENT_OUT_LO +: 16] == evt_q[15:0])
    else $error("bad virtual entry");
  AST_BARRIER_STALL: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == cmd_exec_pkg::S_SYNC && !rdAck |=> state_q == cmd_exec_pkg::S_SYNC)
    else $error("barrier left early");
  AST_VIRT_GATE: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == cmd_exec_pkg::S_VPE |-> ctrl_q[cmd_exec_pkg::CTRL_VIRT])
    else $error("virtual command without capability");
endmodule
`default_nettype wire

// File: logic/cmd_exec_pkg.sv
// How it works
// - four-doubleword packets, opcode low byte, in order
// - collection move rewrites entry collection, moves pending
// - collection move errors: virtual, out of range, unmapped
// - collection move checks in the fixed order
// - error: system error if flag set, advance, no writes
// - different targets: transfer pending state, race-safe
// - success: store collection, write back, then advance
// - barrier stalls until target operations observed
// - after barrier earlier commands affect later requests
// - barrier target read as address or processor number
// - invalidate-all refreshes cached virtual PE configuration
// - invalidate-all errors: PE out of range, unmapped
// - virtual commands only when virtualization capable
// - map identity writes valid virtual entry, id equals event
// - map identity checks in the fixed order
// - doorbell valid if 1023 or inside interrupt range
package cmd_exec_pkg;
  // opcodes
  localparam logic [7:0] OP_COLL_MOVE = 8'h01;
  localparam logic [7:0] OP_BARRIER = 8'h05;
  localparam logic [7:0] OP_VIRT_INVAL = 8'h2d;
  localparam logic [7:0] OP_VIRT_MAP = 8'h2b;
  // interrupt id figures
  localparam logic [31:0] LOCAL_INT_MIN = 32'h00002000;
  localparam logic [31:0] NO_DOORBELL = 32'h000003ff;
  // queue geometry: 4 packets of 8 words
  localparam int QUEUE_PACKETS = 4;
  localparam int PACKET_WORDS = 8;
  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_LIMITS = 12'h004;
  localparam logic [11:0] REG_IDBITS = 12'h008;
  localparam logic [11:0] REG_WRPTR = 12'h00c;
  localparam logic [11:0] REG_RDPTR = 12'h010;
  localparam logic [11:0] REG_STATE = 12'h014;
  localparam logic [11:0] REG_IRQ_STAT = 12'h018;
  localparam logic [11:0] REG_IRQ_MASK = 12'h01c;
  localparam logic [11:0] REG_QUEUE = 12'h100;
  // control fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_SYSERR = 1;
  localparam int CTRL_TGTFMT = 2;
  localparam int CTRL_VIRT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [31:0] LIMITS_RESET = 32'h00000000;
  localparam logic [4:0] IDBITS_RESET = 5'h0d;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_BARRIER = 2;
  // table selects
  localparam logic [1:0] TAB_DEVICE = 2'h0;
  localparam logic [1:0] TAB_TRANSLATION = 2'h1;
  localparam logic [1:0] TAB_COLLECTION = 2'h2;
  localparam logic [1:0] TAB_VPE = 2'h3;
  // redistributor operations
  localparam logic [1:0] RD_MOVE = 2'h0;
  localparam logic [1:0] RD_BARRIER = 2'h1;
  localparam logic [1:0] RD_INVAL = 2'h2;
  // entry field positions
  localparam int ENT_VALID = 0;
  localparam int ENT_VIRT = 1;
  localparam int ENT_TGT_LO = 2;
  localparam int ENT_OUT_LO = 18;
  localparam int ENT_BELL_LO = 34;
  localparam int DEV_SIZE_LO = 1;
  localparam int DEV_NUM_BITS = 16;
  typedef enum {S_IDLE, S_DECODE, S_DEV, S_ITE, S_COL1, S_COL2, S_MOVE, S_WRITE,
    S_SYNC, S_VPE, S_INVAL, S_ADV} exec_state_t;
endpackage

// File: verif/table_model.sv
`timescale 1ns/1ps
`default_nettype none
module table_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // table memory port
  input wire logic tabReq,
  input wire logic tabWrite,
  input wire logic [1:0] tabSel,
  input wire logic [31:0] tabDev,
  input wire logic [31:0] tabIdx,
  input wire logic [63:0] tabWdata,
  output logic tabAck,
  output logic [63:0] tabRdata,
  // redistributor port
  input wire logic rdReq,
  input wire logic [1:0] rdOp,
  input wire logic [34:0] rdDst,
  input wire logic [31:0] rdId,
  output logic rdAck
);
  logic [63:0] mem [logic [25:0]];
  int tabDelay = 1;
  int rdDelay = 1;
  int tabCnt = 0;
  int rdCnt = 0;
  int wrCount = 0;
  int accCount = 0;
  logic [63:0] lastWr;
  logic [36:0] lastRd;
  // only the translation table is indexed per device
  function automatic logic [25:0] key(input logic [1:0] s, input logic [31:0] d,
    input logic [31:0] i);
    return {s, (s == cmd_exec_pkg::TAB_TRANSLATION) ? d[7:0] : 8'h0, i[15:0]};
  endfunction
  // table memory; data flips when idle so stale data looks valid only every other cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tabAck <= 1'b0;
      tabRdata <= 64'h0;
    end else begin
      tabAck <= 1'b0;
      tabRdata <= ~tabRdata;
      if (tabReq && !tabAck && tabCnt < tabDelay) begin
        tabCnt++;
      end else if (tabReq && !tabAck) begin
        tabCnt = 0;
        accCount++;
        tabAck <= 1'b1;
        if (tabWrite) begin
          mem[key(tabSel, tabDev, tabIdx)] = tabWdata;
          wrCount++;
          lastWr = tabWdata;
        end else begin
          tabRdata <= mem.exists(key(tabSel, tabDev, tabIdx)) ?
            mem[key(tabSel, tabDev, tabIdx)] : 64'h0;
        end
      end
    end
  end
  // redistributor: the acknowledge means the operation is globally observed
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdAck <= 1'b0;
    end else begin
      rdAck <= 1'b0;
      if (rdReq && !rdAck && rdCnt < rdDelay) begin
        rdCnt++;
      end else if (rdReq && !rdAck) begin
        rdCnt = 0;
        rdAck <= 1'b1;
        lastRd = {rdOp, rdDst};
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, sysError, irq, ev;
  logic tabReq, tabWrite, tabAck, rdReq, rdAck;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, tabDev, tabIdx, rdId;
  logic [1:0] tabSel, rdOp, wp;
  logic [63:0] tabWdata, tabRdata;
  logic [34:0] rdSrc, rdDst;
  int fail_count = 0;
  int checks = 0;
  int seCount = 0;
  int dW, dE, dA;
  realtime tWait;
  cmd_exec dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tabReq, .tabWrite, .tabSel, .tabDev, .tabIdx, .tabWdata, .tabAck, .tabRdata,
    .rdReq, .rdOp, .rdSrc, .rdDst, .rdId, .rdAck, .sysError, .irq);
  table_model m (.clk, .rst_b, .tabReq, .tabWrite, .tabSel, .tabDev, .tabIdx, .tabWdata,
    .tabAck, .tabRdata, .rdReq, .rdOp, .rdDst, .rdId, .rdAck);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // system error pulses last one cycle, so count every high edge
  always @(posedge clk) if (sysError === 1'b1) seCount++;
  function automatic logic [63:0] ent(logic vt, logic [15:0] c, logic [15:0] o, logic [15:0] b);
    return {14'h0, b, o, c, vt, 1'b1};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // a slave that never answers counts against the run
    if (pready !== 1'b1) fail_count++;
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one packet per call, queue slots used in order
  task automatic cmd(input logic [31:0] w0, w1, w2, w3, w4, w5);
    logic [31:0] w [8];
    int n, w0c, e0, a0;
    realtime t0;
    w = '{w0, w1, w2, w3, w4, w5, 32'h0, 32'h0};
    w0c = m.wrCount;
    e0 = seCount;
    a0 = m.accCount;
    for (int i = 0; i < 8; i++) apb(1'b1, 12'h100 + 12'(wp) * 12'h020 + 12'(i * 4), w[i]);
    wp = wp + 2'h1;
    apb(1'b1, cmd_exec_pkg::REG_WRPTR, {30'h0, wp});
    t0 = $realtime;
    n = 0;
    do begin
      apb(1'b0, cmd_exec_pkg::REG_RDPTR, 32'h0);
      n++;
    end while (rv[1:0] !== wp && n < 200);
    // a command that never retires counts against the run
    if (rv[1:0] !== wp) fail_count++;
    tWait = $realtime - t0;
    dW = m.wrCount - w0c;
    dE = seCount - e0;
    dA = m.accCount - a0;
  endtask
  task automatic t_regs;
    apb(1'b0, cmd_exec_pkg::REG_IDBITS, 32'h0);
    `CHK(rv[4:0], cmd_exec_pkg::IDBITS_RESET)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({ev, rv}, {1'b1, 32'h0})
    apb(1'b1, cmd_exec_pkg::REG_LIMITS, 32'h00040004);
    apb(1'b1, cmd_exec_pkg::REG_IDBITS, 32'he);
    apb(1'b1, cmd_exec_pkg::REG_IRQ_MASK, 32'h2);
    apb(1'b1, cmd_exec_pkg::REG_CTRL, 32'h9);
  endtask
  task automatic t_move;
    m.rdDelay = 5;
    cmd(cmd_exec_pkg::OP_COLL_MOVE, 1, 5, 0, 2, 0);
    `CHK(m.lastWr, ent(1'b0, 16'h2, 16'h2005, 16'h0))
    `CHK(m.lastRd, {cmd_exec_pkg::RD_MOVE, 35'h20})
    `CHK({rdSrc, rdId}, {35'h10, 32'h2005})
    `CHK({dW, dE}, {32'd1, 32'd0})
  endtask
  task automatic t_barrier;
    m.rdDelay = 40;
    cmd(cmd_exec_pkg::OP_BARRIER, 0, 0, 0, 32'h00100000, 32'h1);
    `CHK(m.lastRd, {cmd_exec_pkg::RD_BARRIER, 35'h10})
    `CHK(tWait >= 200.0, 1'b1)
    m.rdDelay = 1;
    cmd(cmd_exec_pkg::OP_COLL_MOVE, 1, 5, 0, 1, 0);
    `CHK(m.lastWr, ent(1'b0, 16'h1, 16'h2005, 16'h0))
    apb(1'b1, cmd_exec_pkg::REG_CTRL, 32'hf);
    cmd(cmd_exec_pkg::OP_BARRIER, 0, 0, 0, 32'h00100000, 32'h1);
    `CHK(m.lastRd, {cmd_exec_pkg::RD_BARRIER, 35'h10010})
  endtask
  task automatic t_errors;
    apb(1'b1, cmd_exec_pkg::REG_CTRL, 32'hb);
    cmd(cmd_exec_pkg::OP_COLL_MOVE, 1, 5, 0, 3, 0);
    `CHK({dW, dE}, {32'd0, 32'd1})
    `CHK(irq, 1'b1)
    cmd(cmd_exec_pkg::OP_COLL_MOVE, 9, 5, 0, 4, 0);
    `CHK({dA, dE}, {32'd0, 32'd1})
    cmd(cmd_exec_pkg::OP_COLL_MOVE, 1, 32'h8000, 0, 1, 0);
    `CHK({dA, dE}, {32'd1, 32'd1})
    apb(1'b1, cmd_exec_pkg::REG_IRQ_STAT, 32'h7);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_virtual;
    cmd(cmd_exec_pkg::OP_VIRT_MAP, 1, 32'h2000, 2, 0, 32'h3ff);
    `CHK(m.lastWr, ent(1'b1, 16'h2, 16'h2000, 16'h3ff))
    cmd(cmd_exec_pkg::OP_VIRT_MAP, 1, 32'h2001, 2, 0, 32'h2005);
    `CHK({dW, dE}, {32'd1, 32'd0})
    cmd(cmd_exec_pkg::OP_VIRT_MAP, 1, 32'h2002, 2, 0, 32'h500);
    `CHK({dW, dE}, {32'd0, 32'd1})
    cmd(cmd_exec_pkg::OP_VIRT_MAP, 1, 32'h1fff, 2, 0, 32'h3ff);
    `CHK({dW, dE}, {32'd0, 32'd1})
    cmd(cmd_exec_pkg::OP_VIRT_MAP, 1, 32'h2003, 4, 0, 32'h3ff);
    `CHK({dA, dE}, {32'd0, 32'd1})
    cmd(cmd_exec_pkg::OP_COLL_MOVE, 1, 32'h2000, 0, 2, 0);
    `CHK({dW, dE}, {32'd0, 32'd1})
    cmd(cmd_exec_pkg::OP_VIRT_INVAL, 0, 0, 2, 0, 0);
    `CHK(m.lastRd, {cmd_exec_pkg::RD_INVAL, 35'h30})
    `CHK(rdId, 32'h2)
    cmd(cmd_exec_pkg::OP_VIRT_INVAL, 0, 0, 3, 0, 0);
    `CHK(dE, 1)
    apb(1'b1, cmd_exec_pkg::REG_CTRL, 32'h3);
    cmd(cmd_exec_pkg::OP_VIRT_INVAL, 0, 0, 2, 0, 0);
    `CHK(dE, 1)
  endtask
  task automatic test_done;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // tables: device 1, event 5 in collection 1, collections 1 and 2, virtual PE 2
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    wp = 2'h0;
    m.mem[m.key(cmd_exec_pkg::TAB_DEVICE, 0, 1)] = 64'h1d;
    m.mem[m.key(cmd_exec_pkg::TAB_TRANSLATION, 1, 5)] = ent(1'b0, 16'h1, 16'h2005, 16'h0);
    m.mem[m.key(cmd_exec_pkg::TAB_COLLECTION, 0, 1)] = 64'h21;
    m.mem[m.key(cmd_exec_pkg::TAB_COLLECTION, 0, 2)] = 64'h41;
    m.mem[m.key(cmd_exec_pkg::TAB_VPE, 0, 2)] = 64'h61;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_move;
    t_barrier;
    t_errors;
    t_virtual;
    test_done;
  end
  // a hung handshake ends the run the same way
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    test_done;
  end
endmodule
`default_nettype wire
